/* hdl/dsl_pkg.sv */
// Package for the drive status LED indicator.
// Assumes a 125 MHz core clock; all periods are cycle counts derived here.
package dsl_pkg;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int unsigned CLK_MHZ          = 125;
  localparam int unsigned FLASH_PERIOD_MS  = 400;  // Flashing period (on+off)
  localparam int unsigned RAPID_PERIOD_MS  = 100;  // Rapid flashing period
  localparam int unsigned PULSE_MS         = 200;  // One pulse of a n-flash
  localparam int unsigned PULSE_GAP_MS     = 200;  // Gap between pulses
  localparam int unsigned BURST_PAUSE_MS   = 1000; // Dark pause after a burst
  localparam int unsigned CONFIRM_TIME_S   = 30;   // Step four auto return
  localparam int unsigned FLASH_HALF_CYC   = FLASH_PERIOD_MS * CLK_MHZ * 1000 / 2;
  localparam int unsigned RAPID_HALF_CYC   = RAPID_PERIOD_MS * CLK_MHZ * 1000 / 2;
  localparam int unsigned PULSE_CYC        = PULSE_MS * CLK_MHZ * 1000;
  localparam int unsigned PULSE_GAP_CYC    = PULSE_GAP_MS * CLK_MHZ * 1000;
  localparam int unsigned BURST_PAUSE_CYC  = BURST_PAUSE_MS * CLK_MHZ * 1000;
  localparam longint unsigned CONFIRM_CYC  = 64'(CONFIRM_TIME_S) * CLK_MHZ * 1000000;

  // ---------------------------------------------------------------------
  // Encodings
  // ---------------------------------------------------------------------
  localparam logic [3:0] STATE_SELF_TEST   = 4'h0;
  localparam logic [3:0] STATE_READY_ON    = 4'h2;
  localparam logic [3:0] STATE_ENABLED     = 4'h4;
  localparam logic [2:0] SAFETY_STEP_IDLE  = 3'h0;
  localparam logic [2:0] SAFETY_STEP_ONE   = 3'h1;
  localparam logic [2:0] SAFETY_STEP_TWO   = 3'h2;
  localparam logic [2:0] SAFETY_STEP_THREE = 3'h3;
  localparam logic [2:0] SAFETY_STEP_FOUR  = 3'h4;
  localparam logic [7:0] LIFE_REPLACE_PCT  = 8'h5a; // 90 percent
  localparam logic [7:0] FILE_PREFIX_P     = 8'h50; // Letter P
  localparam logic [7:0] ASCII_ZERO        = 8'h30;
  localparam logic [7:0] ASCII_ONE         = 8'h31;

  // LED patterns; this order sets no priority, the selection logic does
  typedef enum logic [3:0] {
    DSL_PAT_OFF, DSL_PAT_ON, DSL_PAT_FLASH, DSL_PAT_RAPID,
    DSL_PAT_SINGLE, DSL_PAT_DOUBLE, DSL_PAT_TRIPLE,
    DSL_PAT_SINGLE_INV, DSL_PAT_DOUBLE_INV
  } dsl_pat_t;

endpackage

/* hdl/dsl_indicator.sv */
// Drive status LED indicator: run LED, two axis error LEDs, maintenance flags.
// Assumes all inputs except the button arrive from logic on core_clk_in.
`timescale 1ns/1ps

module dsl_indicator (
  // Clock and reset
  input  wire logic        core_clk_in,
  input  wire logic        reset_n_in,
  // Drive state
  input  wire logic [3:0]  device_state_code_in,
  input  wire logic        double_axis_in,
  input  wire logic        startup_phase_in,
  input  wire logic        new_firmware_in,
  input  wire logic [1:0]  axis_fault_in,
  input  wire logic [1:0]  axis_warning_in,
  input  wire logic [1:0]  safe_torque_off_in,
  input  wire logic        storage_write_in,
  input  wire logic        config_active_in,
  input  wire logic        config_mismatch_in,
  input  wire logic [2:0]  safety_step_in,
  input  wire logic        identify_in,
  // Operator button, asynchronous
  input  wire logic        operator_push_button_in,
  // Predictive maintenance
  input  wire logic        maint_active_in,
  input  wire logic [1:0]  axis_enable_param_in,
  input  wire logic        life_update_in,
  input  wire logic        life_axis_in,
  input  wire logic [7:0]  life_value_in,
  input  wire logic        serial_valid_in,
  input  wire logic [31:0] serial_digits_in,
  input  wire logic [31:0] axis_identity_param_in,
  input  wire logic        file_axis_in,
  input  wire logic        file_backup_in,
  // LEDs
  output logic             run_led_out,
  output logic [1:0]       err_led_out,
  // Maintenance results
  output logic [1:0]       replace_message_param_out,
  output logic [15:0]      life_indicator_param_out,
  output logic [63:0]      file_name_out,
  output logic [23:0]      file_ext_out
);

  // -----------------------------------------------------------------------
  // Pattern timebase
  // -----------------------------------------------------------------------
  // Flash timebase counters and phases
  logic [31:0] flash_cnt_ff;
  logic [31:0] rapid_cnt_ff;
  logic [31:0] burst_cnt_ff;
  logic [2:0]  burst_idx_ff;
  logic        flash_ph_ff;
  logic        rapid_ph_ff;
  // Button synchroniser and confirmation timer
  logic [1:0]  btn_sync_ff;
  logic        btn_prev_ff;
  logic [63:0] confirm_cnt_ff;
  logic        confirm_ff;
  logic [2:0]  step_prev_ff;
  // Pattern chosen for each LED
  logic [31:0] burst_lim;
  dsl_pkg::dsl_pat_t run_pat;
  dsl_pkg::dsl_pat_t err_pat [2];

  // Steady and rapid flash squares
  // Both start dark; the periods are long
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      flash_cnt_ff <= 32'h0;
      flash_ph_ff  <= 1'b0;
    end else if (flash_cnt_ff == dsl_pkg::FLASH_HALF_CYC - 1) begin
      flash_cnt_ff <= 32'h0;
      flash_ph_ff  <= ~flash_ph_ff;
    end else begin
      flash_cnt_ff <= flash_cnt_ff + 32'h1;
    end
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rapid_cnt_ff <= 32'h0;
      rapid_ph_ff  <= 1'b0;
    end else if (rapid_cnt_ff == dsl_pkg::RAPID_HALF_CYC - 1) begin
      rapid_cnt_ff <= 32'h0;
      rapid_ph_ff  <= ~rapid_ph_ff;
    end else begin
      rapid_cnt_ff <= rapid_cnt_ff + 32'h1;
    end
  end

  // Burst sequencer: slots 0,2,4 are pulses, 1,3 gaps, 5 the long pause
  // Plain bursts open lit in slot 0, inverse ones dark; one sequencer keeps LEDs in step
  always_comb begin
    case (burst_idx_ff)
      3'h0, 3'h2, 3'h4: burst_lim = dsl_pkg::PULSE_CYC - 1;
      3'h1, 3'h3:       burst_lim = dsl_pkg::PULSE_GAP_CYC - 1;
      default:          burst_lim = dsl_pkg::BURST_PAUSE_CYC - 1;
    endcase
  end

  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      burst_cnt_ff <= 32'h0;
      burst_idx_ff <= 3'h0;
    end else if (burst_cnt_ff == burst_lim) begin
      burst_cnt_ff <= 32'h0;
      burst_idx_ff <= (burst_idx_ff == 3'h5) ? 3'h0 : burst_idx_ff + 3'h1;
    end else begin
      burst_cnt_ff <= burst_cnt_ff + 32'h1;
    end
  end

  // Render one pattern at the current time
  // Inverse patterns are the complement of the plain ones
  function automatic logic render(input dsl_pkg::dsl_pat_t pat, input logic fl,
                                  input logic rp, input logic [2:0] idx);
    logic n1;
    logic n2;
    logic n3;
    n1 = (idx == 3'h0);
    n2 = (idx == 3'h0) || (idx == 3'h2);
    n3 = (idx == 3'h0) || (idx == 3'h2) || (idx == 3'h4);
    case (pat)
      dsl_pkg::DSL_PAT_ON:         render = 1'b1;
      dsl_pkg::DSL_PAT_FLASH:      render = fl;
      dsl_pkg::DSL_PAT_RAPID:      render = rp;
      dsl_pkg::DSL_PAT_SINGLE:     render = n1;
      dsl_pkg::DSL_PAT_DOUBLE:     render = n2;
      dsl_pkg::DSL_PAT_TRIPLE:     render = n3;
      dsl_pkg::DSL_PAT_SINGLE_INV: render = ~n1;
      dsl_pkg::DSL_PAT_DOUBLE_INV: render = ~n2;
      default:                     render = 1'b0;
    endcase
  endfunction

  // -----------------------------------------------------------------------
  // Operator button and step four confirmation
  // -----------------------------------------------------------------------
  // Two-stage synchroniser, then rising edge on the second stage
  // Only the second stage is read, to keep metastability out
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      btn_sync_ff <= 2'h0;
      btn_prev_ff <= 1'b0;
    end else begin
      btn_sync_ff <= {btn_sync_ff[0], operator_push_button_in};
      btn_prev_ff <= btn_sync_ff[1];
    end
  end

  // Double flash holds from entry into step four until button or timeout
  // Entry wins over a press in the same cycle
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      step_prev_ff   <= dsl_pkg::SAFETY_STEP_IDLE;
      confirm_ff     <= 1'b0;
      confirm_cnt_ff <= 64'h0;
    end else begin
      step_prev_ff <= safety_step_in;
      if (safety_step_in == dsl_pkg::SAFETY_STEP_FOUR &&
          step_prev_ff != dsl_pkg::SAFETY_STEP_FOUR) begin
        confirm_ff     <= 1'b1;
        confirm_cnt_ff <= 64'h0;
      end else if (confirm_ff) begin
        if ((btn_sync_ff[1] && !btn_prev_ff) ||
            confirm_cnt_ff == dsl_pkg::CONFIRM_CYC - 1) begin
          confirm_ff <= 1'b0;
        end
        confirm_cnt_ff <= confirm_cnt_ff + 64'h1;
      end
    end
  end

  // -----------------------------------------------------------------------
  // Pattern selection by priority
  // -----------------------------------------------------------------------
  // Run LED: start-up, identify, safety steps, storage, then drive state
  // Safety steps outrank faults so activation can be finished
  always_comb begin
    run_pat = dsl_pkg::DSL_PAT_OFF;
    if (startup_phase_in) begin
      run_pat = dsl_pkg::DSL_PAT_ON;
    end else if (identify_in) begin
      run_pat = dsl_pkg::DSL_PAT_RAPID;
    end else if (safety_step_in == dsl_pkg::SAFETY_STEP_THREE) begin
      run_pat = dsl_pkg::DSL_PAT_TRIPLE;
    end else if (confirm_ff) begin
      run_pat = dsl_pkg::DSL_PAT_DOUBLE;
    end else if (storage_write_in) begin
      run_pat = dsl_pkg::DSL_PAT_RAPID;
    end else if (device_state_code_in == dsl_pkg::STATE_SELF_TEST) begin
      run_pat = dsl_pkg::DSL_PAT_SINGLE;
    end else if ((|axis_fault_in) || (|safe_torque_off_in)) begin
      run_pat = dsl_pkg::DSL_PAT_OFF;
    end else if (device_state_code_in == dsl_pkg::STATE_ENABLED) begin
      run_pat = dsl_pkg::DSL_PAT_ON;
    end else if (device_state_code_in == dsl_pkg::STATE_READY_ON) begin
      run_pat = dsl_pkg::DSL_PAT_FLASH;
    end
  end

  // Error LEDs, one per axis
  // Safe torque off outranks a fault only with newer firmware
  for (genvar ax = 0; ax < 2; ax++) begin : g_err
    always_comb begin
      err_pat[ax] = dsl_pkg::DSL_PAT_OFF;
      if (startup_phase_in) begin
        err_pat[ax] = dsl_pkg::DSL_PAT_ON;
      end else if (identify_in) begin
        err_pat[ax] = dsl_pkg::DSL_PAT_RAPID;
      end else if (safety_step_in == dsl_pkg::SAFETY_STEP_THREE) begin
        err_pat[ax] = dsl_pkg::DSL_PAT_TRIPLE;
      end else if (safety_step_in == dsl_pkg::SAFETY_STEP_TWO) begin
        err_pat[ax] = dsl_pkg::DSL_PAT_DOUBLE_INV;
      end else if (config_mismatch_in ||
                   safety_step_in == dsl_pkg::SAFETY_STEP_ONE) begin
        err_pat[ax] = dsl_pkg::DSL_PAT_DOUBLE;
      end else if (!config_active_in) begin
        err_pat[ax] = dsl_pkg::DSL_PAT_RAPID;
      end else if (new_firmware_in && safe_torque_off_in[ax]) begin
        err_pat[ax] = axis_fault_in[ax] ? dsl_pkg::DSL_PAT_SINGLE_INV
                                        : dsl_pkg::DSL_PAT_SINGLE;
      end else if (axis_fault_in[ax]) begin
        err_pat[ax] = dsl_pkg::DSL_PAT_ON;
      end else if (axis_warning_in[ax]) begin
        err_pat[ax] = dsl_pkg::DSL_PAT_FLASH;
      end
    end
  end

  // -----------------------------------------------------------------------
  // LED outputs
  // -----------------------------------------------------------------------
  // Registered LEDs; axis B stays dark on a single-axis unit
  // LEDs lag their inputs by one cycle
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      run_led_out <= 1'b0;
      err_led_out <= 2'h0;
    end else begin
      run_led_out    <= render(run_pat, flash_ph_ff, rapid_ph_ff, burst_idx_ff);
      err_led_out[0] <= render(err_pat[0], flash_ph_ff, rapid_ph_ff, burst_idx_ff);
      err_led_out[1] <= double_axis_in &&
                        render(err_pat[1], flash_ph_ff, rapid_ph_ff, burst_idx_ff);
    end
  end

  // -----------------------------------------------------------------------
  // Life indicator and replacement recommendation
  // -----------------------------------------------------------------------
  // Per axis: accept only while enabled and only if not lower
  // A refused update is dropped with no indication
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      life_indicator_param_out <= 16'h0;
    end else if (life_update_in && axis_enable_param_in[life_axis_in]) begin
      if (life_axis_in) begin
        if (life_value_in > life_indicator_param_out[15:8]) begin
          life_indicator_param_out[15:8] <= life_value_in;
        end
      end else if (life_value_in > life_indicator_param_out[7:0]) begin
        life_indicator_param_out[7:0] <= life_value_in;
      end
    end
  end

  // Recommendation from the stored indicator
  // It follows the stored byte one cycle later
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      replace_message_param_out <= 2'h0;
    end else begin
      replace_message_param_out[0] <= maint_active_in &&
        life_indicator_param_out[7:0] >= dsl_pkg::LIFE_REPLACE_PCT;
      replace_message_param_out[1] <= maint_active_in &&
        life_indicator_param_out[15:8] >= dsl_pkg::LIFE_REPLACE_PCT;
    end
  end

  // -----------------------------------------------------------------------
  // Maintenance file name
  // -----------------------------------------------------------------------
  // CRC-32 (reflected) of the identity word, bit by bit from bit 0
  // Used only when no serial number is available
  function automatic logic [31:0] crc32(input logic [31:0] d);
    logic [31:0] c;
    c = 32'hffffffff;
    for (int i = 0; i < 32; i++) begin
      c = ((c[0] ^ d[i]) ? 32'hedb88320 : 32'h0) ^ {1'b0, c[31:1]};
    end
    crc32 = ~c;
  endfunction

  // Nibble to upper-case hex character
  // Digits above nine map to A to F
  function automatic logic [7:0] hexch(input logic [3:0] n);
    hexch = (n < 4'ha) ? 8'(dsl_pkg::ASCII_ZERO + 8'(n)) : 8'(8'h37 + 8'(n));
  endfunction

  logic [31:0] name_src;
  assign name_src = serial_valid_in ? serial_digits_in
                                    : crc32(axis_identity_param_in);

  // Registered name and extension
  // Extension digits: axis first, then backup copy
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      file_name_out <= 64'h0;
      file_ext_out  <= 24'h0;
    end else begin
      for (int k = 0; k < 8; k++) begin
        file_name_out[k*8 +: 8] <= hexch(name_src[k*4 +: 4]);
      end
      file_ext_out <= {dsl_pkg::FILE_PREFIX_P,
                       file_axis_in ? dsl_pkg::ASCII_ONE : dsl_pkg::ASCII_ZERO,
                       file_backup_in ? dsl_pkg::ASCII_ONE : dsl_pkg::ASCII_ZERO};
    end
  end

endmodule

/* tb/dsl_indicator_sva.sv */
// Checker for the LED indicator: steady LED levels and maintenance outputs.
// Assumes it is bound to dsl_indicator; flash phases are not judged here.
`timescale 1ns/1ps
module dsl_indicator_sva (
  // Clock and reset
  input wire logic        core_clk_in,
  input wire logic        reset_n_in,
  // Drive state
  input wire logic [3:0]  device_state_code_in,
  input wire logic        double_axis_in,
  input wire logic        startup_phase_in,
  input wire logic        new_firmware_in,
  input wire logic [1:0]  axis_fault_in,
  input wire logic [1:0]  axis_warning_in,
  input wire logic [1:0]  safe_torque_off_in,
  input wire logic        storage_write_in,
  input wire logic        config_active_in,
  input wire logic        config_mismatch_in,
  input wire logic [2:0]  safety_step_in,
  input wire logic        identify_in,
  input wire logic        operator_push_button_in,
  // Maintenance
  input wire logic        maint_active_in,
  input wire logic [1:0]  axis_enable_param_in,
  input wire logic        life_update_in,
  input wire logic        life_axis_in,
  input wire logic [7:0]  life_value_in,
  input wire logic        file_axis_in,
  input wire logic        file_backup_in,
  // Outputs watched
  input wire logic        run_led_out,
  input wire logic [1:0]  err_led_out,
  input wire logic [1:0]  replace_message_param_out,
  input wire logic [15:0] life_indicator_param_out,
  input wire logic [23:0] file_ext_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!reset_n_in);

  // ---------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------
  logic       pend_ff;
  logic [3:0] btn_cnt_ff;
  logic       run_q;
  logic       red_q;

  // Counts how long the button has been held
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) btn_cnt_ff <= 4'h0;
    else if (!operator_push_button_in) btn_cnt_ff <= 4'h0;
    else if (btn_cnt_ff != 4'hf) btn_cnt_ff <= btn_cnt_ff + 4'h1;
  end

  // Step four confirmation may still be showing on the run LED
  always_ff @(posedge core_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) pend_ff <= 1'b0;
    else if (safety_step_in == dsl_pkg::SAFETY_STEP_FOUR) pend_ff <= 1'b1;
    else if (btn_cnt_ff > 4'h5) pend_ff <= 1'b0;
  end

  // No higher-priority pattern is claiming the LEDs
  assign run_q = !startup_phase_in && !identify_in && !storage_write_in && !pend_ff
                 && safety_step_in != dsl_pkg::SAFETY_STEP_THREE;
  assign red_q = !startup_phase_in && !identify_in && !config_mismatch_in && config_active_in
                 && !(safety_step_in inside {3'h1, 3'h2, 3'h3});

  // ---------------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------------
  property p_run_dark;
    run_q && device_state_code_in != dsl_pkg::STATE_SELF_TEST
      && (|axis_fault_in || |safe_torque_off_in) |=> !run_led_out;
  endproperty
  a_run_dark: assert property (p_run_dark)
    else $error("run LED lit during fault");

  property p_run_on;
    run_q && device_state_code_in == dsl_pkg::STATE_ENABLED && !(|axis_fault_in)
      && !(|safe_torque_off_in) |=> run_led_out;
  endproperty
  a_run_on: assert property (p_run_on)
    else $error("run LED dark while enabled");

  property p_red_on;
    red_q && axis_fault_in[0] && !(new_firmware_in && safe_torque_off_in[0])
      |=> err_led_out[0];
  endproperty
  a_red_on: assert property (p_red_on)
    else $error("red LED dark on fault");

  property p_red_off;
    red_q && !axis_fault_in[0] && !axis_warning_in[0] && !safe_torque_off_in[0]
      |=> !err_led_out[0];
  endproperty
  a_red_off: assert property (p_red_off)
    else $error("red LED lit without cause");

  property p_startup;
    reset_n_in && startup_phase_in
      |=> run_led_out && err_led_out == {$past(double_axis_in), 1'b1};
  endproperty
  a_startup: assert property (p_startup)
    else $error("start-up LEDs not all lit");

  property p_ext;
    reset_n_in |=> file_ext_out == {dsl_pkg::FILE_PREFIX_P, 7'h18, $past(file_axis_in),
                              7'h18, $past(file_backup_in)};
  endproperty
  a_ext: assert property (p_ext)
    else $error("file extension wrong");

  property p_life_mono;
    1'b1 |=> life_indicator_param_out[7:0] >= $past(life_indicator_param_out[7:0]);
  endproperty
  a_life_mono: assert property (p_life_mono)
    else $error("life indicator dropped");

  property p_life_hold;
    !(life_update_in && !life_axis_in && axis_enable_param_in[0])
      |=> $stable(life_indicator_param_out[7:0]);
  endproperty
  a_life_hold: assert property (p_life_hold)
    else $error("life indicator moved without update");

  property p_replace;
    life_update_in && !life_axis_in && axis_enable_param_in[0] && maint_active_in
      && life_value_in >= dsl_pkg::LIFE_REPLACE_PCT |-> ##2 replace_message_param_out[0];
  endproperty
  a_replace: assert property (p_replace)
    else $error("replace recommendation missing");

  // Main scenarios reached
  c_startup: cover property (startup_phase_in ##1 run_led_out);
  c_fault: cover property (red_q && axis_fault_in[0] ##1 err_led_out[0]);
  c_replace: cover property ($rose(replace_message_param_out[0]));
endmodule

bind dsl_indicator dsl_indicator_sva u_sva (.*);

/* tb/dsl_operator_model.sv */
// Operator model: the front panel push button pressed by a person.
// Assumes press_in from the bench; the contact changes off the clock edge.
`timescale 1ns/1ps
module dsl_operator_model (
  // Request from the bench
  input  wire logic press_in,
  // Button contact
  output logic      operator_push_button_out
);
  // Button follows the hand after a short mechanical delay
  initial operator_push_button_out = 1'b0;
  always @(press_in) operator_push_button_out <= #3 press_in;
endmodule

/* tb/tb.sv */
// Testbench for the LED indicator: steady LED levels, life and file naming.
// Assumes the package periods are long: flashes sit in their first phase.
`timescale 1ns/1ps
module tb;
  // ---------------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------------
  logic        core_clk_in = 1'b0;
  logic        reset_n_in = 1'b0;
  logic [3:0]  device_state_code_in = 4'h0;
  logic        double_axis_in = 1'b1;
  logic        startup_phase_in = 1'b1;
  logic        new_firmware_in = 1'b0;
  logic [1:0]  axis_fault_in = 2'h0;
  logic [1:0]  axis_warning_in = 2'h0;
  logic [1:0]  safe_torque_off_in = 2'h0;
  logic        storage_write_in = 1'b0;
  logic        config_active_in = 1'b0;
  logic        config_mismatch_in = 1'b0;
  logic [2:0]  safety_step_in = 3'h0;
  logic        identify_in = 1'b0;
  logic        operator_push_button_in;
  logic        press_req = 1'b0;
  logic        maint_active_in = 1'b1;
  logic [1:0]  axis_enable_param_in = 2'h1;
  logic        life_update_in = 1'b0;
  logic        life_axis_in = 1'b0;
  logic [7:0]  life_value_in = 8'h00;
  logic        serial_valid_in = 1'b0;
  logic [31:0] serial_digits_in = 32'h0;
  logic [31:0] axis_identity_param_in = 32'h0;
  logic        file_axis_in = 1'b0;
  logic        file_backup_in = 1'b0;
  logic        run_led_out;
  logic [1:0]  err_led_out;
  logic [1:0]  replace_message_param_out;
  logic [15:0] life_indicator_param_out;
  logic [63:0] file_name_out;
  logic [23:0] file_ext_out;
  int          num_errors = 0;
  int          comparisons = 0;

  // Clock, design and operator
  always #4 core_clk_in = ~core_clk_in;
  dsl_indicator uut (.*);
  dsl_operator_model u_op (.press_in(press_req), .operator_push_button_out(operator_push_button_in));

  // ---------------------------------------------------------------------
  // Tasks and expected-value functions
  // ---------------------------------------------------------------------
  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic go(input int n);
    repeat (n) @(posedge core_clk_in);
  endtask

  task automatic look(input int n);
    repeat (n) @(posedge core_clk_in);
    #1;
  endtask

  task automatic life_pulse(input logic ax, input logic [7:0] v);
    go(1);
    life_axis_in <= ax;
    life_value_in <= v;
    life_update_in <= 1'b1;
    go(1);
    life_update_in <= 1'b0;
  endtask

  function automatic logic [63:0] hexstr(input logic [31:0] v);
    for (int i = 0; i < 8; i++)
      hexstr[8*i +: 8] = (v[4*i +: 4] < 4'ha) ? 8'h30 + 8'(v[4*i +: 4]) : 8'h37 + 8'(v[4*i +: 4]);
  endfunction

  function automatic logic [31:0] crc32(input logic [31:0] d);
    logic [31:0] c;
    c = 32'hffffffff;
    for (int i = 0; i < 32; i++)
      c = (c[0] ^ d[i]) ? (c >> 1) ^ 32'hedb88320 : c >> 1;
    return ~c;
  endfunction

  task automatic finish_test;
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------------
  initial begin
    go(8);
    reset_n_in <= 1'b1;
    look(3);
    check("startup leds", {run_led_out, err_led_out}, 64'h7);
    go(1);
    startup_phase_in <= 1'b0;
    config_active_in <= 1'b1;
    device_state_code_in <= dsl_pkg::STATE_ENABLED;
    look(3);
    check("run enabled", run_led_out, 1'b1);
    check("red idle", err_led_out, 2'h0);
    go(1);
    axis_fault_in <= 2'h2;
    look(3);
    check("run fault", run_led_out, 1'b0);
    check("red fault", err_led_out, 2'h2);
    go(1);
    axis_fault_in <= 2'h0;
    safe_torque_off_in <= 2'h1;
    look(3);
    check("run sto", run_led_out, 1'b0);
    go(1);
    safe_torque_off_in <= 2'h0;
    safety_step_in <= dsl_pkg::SAFETY_STEP_FOUR;
    go(4);
    safety_step_in <= dsl_pkg::SAFETY_STEP_IDLE;
    press_req <= 1'b1;
    go(10);
    press_req <= 1'b0;
    look(3);
    check("run after confirm", run_led_out, 1'b1);
    life_pulse(1'b0, 8'h59);
    look(3);
    check("life below", life_indicator_param_out, 16'h0059);
    check("no replace", replace_message_param_out, 2'h0);
    life_pulse(1'b0, 8'h5a);
    look(3);
    check("replace", replace_message_param_out, 2'h1);
    life_pulse(1'b0, 8'h10);
    life_pulse(1'b1, 8'h70);
    look(3);
    check("life hold", life_indicator_param_out, 16'h005a);
    go(1);
    serial_valid_in <= 1'b1;
    serial_digits_in <= 32'h03774434;
    look(2);
    check("serial name", file_name_out, hexstr(32'h03774434));
    go(1);
    serial_valid_in <= 1'b0;
    axis_identity_param_in <= 32'h1234abcd;
    look(2);
    check("crc name", file_name_out, hexstr(crc32(32'h1234abcd)));
    for (int k = 0; k < 4; k++) begin
      go(1);
      file_axis_in <= k[1];
      file_backup_in <= k[0];
      look(2);
      check("extension", file_ext_out, {8'h50, 7'h18, k[1], 7'h18, k[0]});
    end
    // Early after reset a flash shows its dark half, a pulse train its lit one
    go(1);
    storage_write_in <= 1'b1;
    look(2);
    check("run storage", run_led_out, 1'b0);
    go(1);
    storage_write_in <= 1'b0;
    identify_in <= 1'b1;
    axis_fault_in <= 2'h3;
    look(2);
    check("identify", {run_led_out, err_led_out}, 64'h0);
    go(1);
    identify_in <= 1'b0;
    axis_fault_in <= 2'h0;
    safe_torque_off_in <= 2'h1;
    device_state_code_in <= dsl_pkg::STATE_SELF_TEST;
    look(2);
    check("self test", run_led_out, 1'b1);
    go(1);
    safe_torque_off_in <= 2'h0;
    device_state_code_in <= dsl_pkg::STATE_READY_ON;
    look(2);
    check("ready", run_led_out, 1'b0);
    go(1);
    safety_step_in <= dsl_pkg::SAFETY_STEP_THREE;
    look(2);
    check("step three", {run_led_out, err_led_out}, 64'h7);
    go(1);
    safety_step_in <= dsl_pkg::SAFETY_STEP_TWO;
    look(2);
    check("step two", err_led_out, 2'h0);
    go(1);
    safety_step_in <= dsl_pkg::SAFETY_STEP_IDLE;
    config_mismatch_in <= 1'b1;
    look(2);
    check("mismatch", err_led_out, 2'h3);
    go(1);
    config_mismatch_in <= 1'b0;
    config_active_in <= 1'b0;
    axis_fault_in <= 2'h3;
    look(2);
    check("no config", err_led_out, 2'h0);
    go(1);
    config_active_in <= 1'b1;
    new_firmware_in <= 1'b1;
    safe_torque_off_in <= 2'h1;
    axis_fault_in <= 2'h2;
    look(2);
    check("sto single", err_led_out, 2'h3);
    go(1);
    safe_torque_off_in <= 2'h3;
    look(2);
    check("sto inverse", err_led_out, 2'h1);
    go(1);
    new_firmware_in <= 1'b0;
    safe_torque_off_in <= 2'h0;
    axis_fault_in <= 2'h3;
    double_axis_in <= 1'b0;
    look(2);
    check("single axis", err_led_out, 2'h1);
    go(1);
    axis_fault_in <= 2'h0;
    double_axis_in <= 1'b1;
    safety_step_in <= dsl_pkg::SAFETY_STEP_FOUR;
    look(2);
    check("step four", run_led_out, 1'b1);
    go(1);
    safety_step_in <= dsl_pkg::SAFETY_STEP_IDLE;
    press_req <= 1'b1;
    look(6);
    check("step four end", run_led_out, 1'b0);
    go(1);
    press_req <= 1'b0;
    finish_test();
  end

  // Watchdog far beyond the roughly 120 cycles the sequence needs
  initial begin
    #200000;
    num_errors++;
    finish_test();
  end
endmodule
